// ---- hdl/cascade_lane_sync_params.svh ----
// Constants for the cascade lane synchroniser: register offsets, field positions,
// reset values, symbol codes and timing counts. Included by the package and the modules.
`ifndef CASCADE_LANE_SYNC_PARAMS_SVH
`define CASCADE_LANE_SYNC_PARAMS_SVH

// Control bus register offsets (64 byte-wide locations).
`define ADDR_W 6
`define REG_MODE_ADDR 6'h00
`define REG_RECEIVE_CONDITION_B_ADDR 6'h0a

// Mode register fields and reset value.
`define MODE_RUN_BIT 0
`define MODE_CASCADE_BIT 3
`define MODE_RESET 8'h00

// Receive condition B fields and reset value.
`define RCB_CASCADE_SYNC_ERROR_BIT 4
`define RCB_RESET 8'h00

// Five-bit line symbols; a pair carries the first symbol in the upper half.
`define SYM_J 5'h18
`define SYM_K 5'h11
`define SYM_IDLE 5'h1f
`define SYM_T 5'h0d

// Most JK pairs handed to the host before cascade start arrives.
`define MAX_JK_TO_HOST 2'h2

// Window after cascade ready release within which cascade start must be seen.
// It spans eight local byte clock periods, roughly 80 ns.
`define CLK_PERIOD_NS 10
`define CSE_WINDOW_NS 80
`define CSE_WINDOW_CYCLES ((`CSE_WINDOW_NS) / (`CLK_PERIOD_NS))
`define WIN_CNT_W 4

`endif

// ---- hdl/cascade_lane_sync_pkg.sv ----
// Types shared by the cascade lane synchroniser modules.
// Assumes cascade_lane_sync_params.svh is on the include path.
`include "cascade_lane_sync_params.svh"

package cascade_lane_sync_pkg;

  typedef enum logic [1:0] {
    HUNT,
    WAIT_START,
    STREAM
  } syncState_t;

  typedef struct packed {
    syncState_t state;
    logic [1:0] jkSent;
    logic [`WIN_CNT_W-1:0] winCnt;
    logic crRelease;
    logic cascadeSyncError;
    logic [7:0] mode;
    logic [7:0] rdData;
    logic [9:0] hostData;
    logic hostValid;
  } mainState_t;

  typedef struct packed {
    logic startMeta;
    logic startSync;
  } senseState_t;

endpackage

// ---- hdl/lane_sense_if.sv ----
// Carrier between the lane sense module and the synchroniser core.
// Both sides run on the same clock; no timing lives here.
`timescale 1ns/1ps

interface lane_sense_if;
  logic jkNow;
  logic frameEndNow;
  logic startSeen;

  modport sense (
    output jkNow,
    output frameEndNow,
    output startSeen
  );

  modport core (
    input jkNow,
    input frameEndNow,
    input startSeen
  );
endinterface

// ---- hdl/lane_sense.sv ----
// Classifies the received symbol pair and synchronises the cascade start pin.
// Assumes the symbol pair comes from logic on ref_clk and the pin from outside.
`timescale 1ns/1ps
`include "cascade_lane_sync_params.svh"

module lane_sense (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [9:0] rxPair,
  input wire logic rxValid,
  input wire logic cascadeStartIn,
  lane_sense_if.sense sense
);
  import cascade_lane_sync_pkg::*;

  senseState_t st;
  senseState_t next_st;

  function automatic logic isSym(input logic [4:0] sym, input logic [4:0] code);
    return sym == code;
  endfunction

  always_comb begin
    next_st = st;
    next_st.startMeta = cascadeStartIn;
    next_st.startSync = st.startMeta;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Only a cleanly decoded J followed by K counts; a corrupted pair is simply not seen.
  assign sense.jkNow = rxValid && isSym(rxPair[9:5], `SYM_J) && isSym(rxPair[4:0], `SYM_K);
  assign sense.frameEndNow = rxValid && (isSym(rxPair[9:5], `SYM_T) || isSym(rxPair[4:0], `SYM_T) ||
                                         (isSym(rxPair[9:5], `SYM_IDLE) && isSym(rxPair[4:0], `SYM_IDLE)));
  assign sense.startSeen = st.startSync;
endmodule

// ---- hdl/cascade_lane_sync.sv ----
// Cascade lane synchroniser: aligns this lane to its peers on the JK starting
// delimiter through the wired-AND cascade ready / cascade start pair.
// Assumes the received pairs arrive on ref_clk, the local byte clock domain, and that the
// cascade ready pin is an open-drain net pulled high and shared with all peer devices.
`timescale 1ns/1ps
`include "cascade_lane_sync_params.svh"

module cascade_lane_sync #(
  // Cycles of ref_clk after the ready release within which cascade start must arrive; it must fit the counter.
  parameter int WINDOW_CYCLES = `CSE_WINDOW_CYCLES,
  // Most JK pairs shown to the host while this lane waits for its peers.
  parameter int JK_LIMIT = `MAX_JK_TO_HOST
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  // Received symbol pairs from the elasticity buffer.
  input wire logic [9:0] rxPair,
  input wire logic rxValid,
  // Pairs handed to the host framing logic.
  output logic [9:0] hostData,
  output logic hostValid,
  output logic cascadeStarted,
  // Open-drain cascade ready pin, and the wired-AND cascade start net read back.
  input wire logic cascadeReadyIn,
  output logic cascadeReadyOut,
  output logic cascadeReadyOe,
  input wire logic cascadeStartIn,
  // Control bus.
  input wire logic [`ADDR_W-1:0] cbAddr,
  input wire logic [7:0] cbWrData,
  input wire logic cbWrEn,
  input wire logic cbRdEn,
  output logic [7:0] cbRdData,
  output logic cascadeSyncError
);
  import cascade_lane_sync_pkg::*;

  lane_sense_if senseBus ();

  // All state of the core is one packed word, registered in one place; the start pin synchroniser keeps its own in the sense unit.
  mainState_t st;
  mainState_t next_st;

  logic cascadeActive;
  logic windowExpired;
  logic clearSyncError;
  logic [7:0] receiveConditionB;
  logic syncLate;

  // The starting delimiter as presented to the host, first symbol in the upper half.
  localparam logic [9:0] JK_PAIR = {`SYM_J, `SYM_K};

  // A write strobe aimed at one register; every writable location decodes through here.
  function automatic logic writeHit(input logic en, input logic [`ADDR_W-1:0] addr,
                                    input logic [`ADDR_W-1:0] target);
    return en && (addr == target);
  endfunction

  // Symbol classification and the start pin synchroniser live in the sense unit.
  lane_sense senseUnit (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .rxPair(rxPair),
    .rxValid(rxValid),
    .cascadeStartIn(cascadeStartIn),
    .sense(senseBus.sense)
  );

  // Lane synchronisation only runs with the device in run mode and cascade selected.
  assign cascadeActive = st.mode[`MODE_RUN_BIT] && st.mode[`MODE_CASCADE_BIT];

  // The window counts from the release cycle and includes the two-flop delay on the start pin,
  // so a peer that is later than the allowed skew is caught even after synchronisation.
  assign windowExpired = (st.winCnt == `WIN_CNT_W'(WINDOW_CYCLES - 1));

  // Peers missed the window: this lane released ready but the start net has not followed.
  assign syncLate = (st.state == WAIT_START) && cascadeActive && !senseBus.startSeen && windowExpired;

  // Writing a zero to the flag position clears it; other written bits have no effect.
  assign clearSyncError = writeHit(cbWrEn, cbAddr, `REG_RECEIVE_CONDITION_B_ADDR) &&
                          !cbWrData[`RCB_CASCADE_SYNC_ERROR_BIT];

  // Only the sync error flag of receive condition B lives in this block; other bits read zero.
  always_comb begin
    receiveConditionB = `RCB_RESET;
    receiveConditionB[`RCB_CASCADE_SYNC_ERROR_BIT] = st.cascadeSyncError;
  end

  // Next state: register bus first, then the lane state machine, then the sticky flag.
  always_comb begin
    next_st = st;
    next_st.hostValid = 1'b0;

    // Control bus: mode register steers the block, receive condition B shows its state.
    if (writeHit(cbWrEn, cbAddr, `REG_MODE_ADDR)) begin
      next_st.mode = cbWrData;
    end
    // Read data is registered and holds until the next read strobe.
    if (cbRdEn) begin
      unique case (cbAddr)
        `REG_MODE_ADDR: next_st.rdData = st.mode;
        `REG_RECEIVE_CONDITION_B_ADDR: next_st.rdData = receiveConditionB;
        default: next_st.rdData = 8'h00;
      endcase
    end

    unique case (st.state)
      HUNT: begin
        next_st.crRelease = 1'b0;
        next_st.jkSent = 2'h0;
        next_st.winCnt = '0;
        if (!cascadeActive) begin
          // Outside cascade mode this lane simply passes what it receives.
          next_st.hostData = rxPair;
          next_st.hostValid = rxValid;
        end else if (senseBus.jkNow) begin
          // The sender opens every lane with a JK pair; that pair is our alignment mark.
          next_st.crRelease = 1'b1;
          next_st.hostData = JK_PAIR;
          next_st.hostValid = 1'b1;
          next_st.jkSent = 2'h1;
          next_st.state = WAIT_START;
        end
      end

      WAIT_START: begin
        if (!cascadeActive) begin
          // Leaving cascade mode abandons the wait without flagging, since no peer is expected.
          next_st.state = HUNT;
        end else if (senseBus.startSeen) begin
          // Every peer has released its ready line: data may now flow on all lanes.
          next_st.state = STREAM;
          next_st.hostData = rxPair;
          next_st.hostValid = rxValid;
        end else begin
          // Repeat the JK once while peers catch up; never more than two in a row.
          if (rxValid && st.jkSent != 2'(JK_LIMIT)) begin
            next_st.hostData = JK_PAIR;
            next_st.hostValid = 1'b1;
            next_st.jkSent = st.jkSent + 2'h1;
          end
          if (!windowExpired) begin
            next_st.winCnt = st.winCnt + `WIN_CNT_W'(1);
          end
        end
      end

      STREAM: begin
        // This device carries its own lane of the aggregate transfer.
        next_st.hostData = rxPair;
        next_st.hostValid = rxValid;
        if (!cascadeActive) begin
          next_st.state = HUNT;
        end else if (senseBus.frameEndNow) begin
          // Ending delimiter or idle: pull ready low again and hunt for the next JK.
          // Re-arming right after a frame could still see the old start level; the idle gap
          // the sender keeps between frames is longer than the two-flop delay on the start pin.
          next_st.state = HUNT;
          next_st.crRelease = 1'b0;
        end
      end

      default: begin
        next_st.state = HUNT;
      end
    endcase

    // Sticky flag: hardware setting it wins over a clear in the same cycle.
    if (clearSyncError) begin
      next_st.cascadeSyncError = 1'b0;
    end
    if (syncLate) begin
      next_st.cascadeSyncError = 1'b1;
    end
  end

  // Reset puts the lane back to hunting, with the mode cleared and the ready line released.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{
        state: HUNT,
        jkSent: 2'h0,
        winCnt: '0,
        crRelease: 1'b0,
        cascadeSyncError: 1'b0,
        mode: `MODE_RESET,
        rdData: 8'h00,
        hostData: 10'h000,
        hostValid: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // Open drain: drive low while not ready, release to let the shared net rise.
  assign cascadeReadyOut = 1'b0;
  assign cascadeReadyOe = cascadeActive && !st.crRelease;

  // Data outputs are registers; the started flag is a plain decode of the state.
  assign hostData = st.hostData;
  assign hostValid = st.hostValid;
  assign cascadeStarted = (st.state == STREAM);
  assign cbRdData = st.rdData;
  assign cascadeSyncError = st.cascadeSyncError;

  // The pin level is read back only through the wired-AND start net; the local view is unused.
  logic unusedReadyIn;
  assign unusedReadyIn = cascadeReadyIn;
endmodule

// ---- sim/lane_sync_checker.sv ----
// Port-level assertions for the cascade lane synchroniser.
// Assumes a single ref_clk domain and the shared constants header.
`timescale 1ns/1ps
`include "cascade_lane_sync_params.svh"
module lane_sync_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [9:0] rxPair,
  input wire logic rxValid,
  input wire logic [9:0] hostData,
  input wire logic hostValid,
  input wire logic cascadeStarted,
  input wire logic cascadeReadyOe,
  input wire logic cascadeStartIn,
  input wire logic [`ADDR_W-1:0] cbAddr,
  input wire logic [7:0] cbWrData,
  input wire logic cbWrEn,
  input wire logic cbRdEn,
  input wire logic [7:0] cbRdData,
  input wire logic cascadeSyncError
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire jkIn = rxValid && rxPair == {`SYM_J, `SYM_K};
  wire clrHit = cbWrEn && cbAddr == `REG_RECEIVE_CONDITION_B_ADDR && !cbWrData[`RCB_CASCADE_SYNC_ERROR_BIT];
  // A mode drop also lowers the enable, so a release is tied to a start pair.
  sequence s_rel;
    $past(jkIn) && $fell(cascadeReadyOe);
  endsequence
  a_jk_release: assert property (cascadeReadyOe && jkIn |=> !cascadeReadyOe) else $error("ready kept");
  a_first_jk: assert property (s_rel |-> hostValid && hostData == {`SYM_J, `SYM_K}) else $error("no jk");
  a_err_sticky: assert property (cascadeSyncError && !clrHit |=> cascadeSyncError) else $error("flag lost");
  a_rd_flag: assert property (cbRdEn && cbAddr == `REG_RECEIVE_CONDITION_B_ADDR |=>
    cbRdData == {3'h0, $past(cascadeSyncError), 4'h0}) else $error("bad flag read");
  a_rd_unmapped: assert property (cbRdEn && cbAddr != 6'h00 && cbAddr != 6'h0a |=>
    cbRdData == 8'h00) else $error("unmapped read not zero");
  a_err_late: assert property (s_rel ##0 !cascadeStarted [*8] ##1 !cascadeStarted |->
    cascadeSyncError) else $error("late start not flagged");
  a_err_early: assert property (s_rel ##0 !cascadeSyncError |-> !cascadeSyncError [*8]) else $error("early flag");
  a_start_gate: assert property ($rose(cascadeStarted) |-> $past(cascadeStartIn, 3)) else $error("no start");
  c_aligned: cover property (s_rel ##[1:6] cascadeStarted);
  c_flag: cover property ($rose(cascadeSyncError));
  c_clear: cover property (clrHit && cascadeSyncError);
endmodule

bind cascade_lane_sync lane_sync_checker u_chk (.ref_clk, .arst_n, .rxPair, .rxValid, .hostData, .hostValid,
  .cascadeStarted, .cascadeReadyOe, .cascadeStartIn, .cbAddr, .cbWrData, .cbWrEn, .cbRdEn, .cbRdData,
  .cascadeSyncError);

// ---- sim/peer_lanes.sv ----
// Behavioural model of the peer devices on the shared ready net.
// Assumes a pulled-up net that every party only pulls low.
`timescale 1ns/1ps
module peer_lanes (
  input wire logic peersReleased,
  input wire logic cascadeReadyOe,
  output logic readyNet,
  output logic startNet
);
  // Peers still hunting for their start pair hold the net low.
  assign readyNet = peersReleased && !cascadeReadyOe;
  assign startNet = readyNet;
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the cascade lane synchroniser.
// Assumes the design files, the package and the peer model are compiled first.
`timescale 1ns/1ps
`include "cascade_lane_sync_params.svh"
module tb_top;
  localparam logic [9:0] JK = {`SYM_J, `SYM_K};
  localparam logic [9:0] DAT = 10'h2a5;
  localparam logic [9:0] ENDP = {`SYM_T, `SYM_T};
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [9:0] rxPair = 10'h3ff;
  logic rxValid = 1'b0;
  logic [5:0] cbAddr = 6'h00;
  logic [7:0] cbWrData = 8'h00;
  logic cbWrEn = 1'b0;
  logic cbRdEn = 1'b0;
  logic peersReleased = 1'b0;
  logic [9:0] hostData;
  logic [7:0] cbRdData;
  logic hostValid, cascadeStarted, cascadeReadyOe, cascadeSyncError, readyNet, startNet;
  int num_errors = 0;
  int num_checks = 0;
  int hostCnt = 0;
  int hostBase = 0;
  logic readyDrive;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (hostValid === 1'b1) hostCnt <= hostCnt + 1;
  cascade_lane_sync uut (.ref_clk, .arst_n, .rxPair, .rxValid, .hostData, .hostValid, .cascadeStarted,
    .cascadeReadyIn(readyNet), .cascadeReadyOut(readyDrive), .cascadeReadyOe, .cascadeStartIn(startNet), .cbAddr,
    .cbWrData, .cbWrEn, .cbRdEn, .cbRdData, .cascadeSyncError);
  peer_lanes peers (.peersReleased, .cascadeReadyOe, .readyNet, .startNet);
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cbAddr = a;
    cbWrData = d;
    cbWrEn = 1'b1;
    @(negedge ref_clk);
    cbWrEn = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    cbAddr = a;
    cbRdEn = 1'b1;
    @(negedge ref_clk);
    cbRdEn = 1'b0;
    check(cbRdData, exp);
  endtask
  task automatic send(input logic [9:0] p, input int n);
    @(negedge ref_clk);
    rxPair = p;
    rxValid = 1'b1;
    repeat (n) @(negedge ref_clk);
    rxValid = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_started();
    int n;
    n = 0;
    while (cascadeStarted !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    check(cascadeStarted, 1'b1);
    if (cascadeStarted !== 1'b1) finish_test();
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    rd(6'h0a, 8'h00);
    wr(6'h15, 8'hff);
    rd(6'h15, 8'h00);
    wr(6'h00, 8'h09);
    rd(6'h00, 8'h09);
    check(cascadeReadyOe, 1'b1);
    $display("test registers done");
    peersReleased = 1'b1;
    send(JK, 1);
    check(hostData, JK);
    check(cascadeReadyOe, 1'b0);
    check(readyDrive, 1'b0);
    send(DAT, 4);
    wait_started();
    check(hostData, DAT);
    send(ENDP, 1);
    check(cascadeSyncError, 1'b0);
    check(cascadeReadyOe, 1'b1);
    $display("test aligned done");
    send({`SYM_IDLE, `SYM_IDLE}, 8);
    peersReleased = 1'b0;
    hostBase = hostCnt;
    send(JK, 1);
    send(DAT, 12);
    check(10'(hostCnt - hostBase), 10'h002);
    check(cascadeSyncError, 1'b1);
    rd(6'h0a, 8'h10);
    wr(6'h0a, 8'h10);
    check(cascadeSyncError, 1'b1);
    peersReleased = 1'b1;
    send(DAT, 3);
    wait_started();
    send(ENDP, 1);
    wr(6'h0a, 8'h00);
    rd(6'h0a, 8'h00);
    send({`SYM_J, `SYM_IDLE}, 1);
    check(cascadeReadyOe, 1'b1);
    check(cascadeSyncError, 1'b0);
    $display("test late peers done");
    wr(6'h00, 8'h01);
    send(DAT, 1);
    check(hostData, DAT);
    check(hostValid, 1'b1);
    check(cascadeReadyOe, 1'b0);
    $display("test plain mode done");
    finish_test();
  end
endmodule
